// File: design/tmr_pkg.sv
package tmr_pkg;

  // ==========================================================
  // special-register numbers
  localparam logic [9:0] SPR_STATUS = 10'h3D8;
  localparam logic [9:0] SPR_CONTROL = 10'h3DA;
  localparam logic [9:0] SPR_INTERVAL = 10'h3DB;

  // ==========================================================
  // control fields, lsb positions (big-endian bit 0 is bit 31)
  localparam int CTL_WDOG_PERIOD = 30;
  localparam int CTL_WDOG_RESET_KIND = 28;
  localparam int CTL_WDOG_IRQ_EN = 27;
  localparam int CTL_INTERVAL_IRQ_EN = 26;
  localparam int CTL_FIXED_PERIOD = 24;
  localparam int CTL_FIXED_IRQ_EN = 23;
  localparam int CTL_AUTO_RELOAD = 22;
  localparam logic [31:0] CTL_IMPL_MASK = 32'hFFC0_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ==========================================================
  // status fields, lsb positions
  localparam int STS_ARM_NEXT = 31;
  localparam int STS_WDOG_IRQ = 30;
  localparam int STS_WDOG_CAUSE = 28;
  localparam int STS_INTERVAL_IRQ = 27;
  localparam int STS_FIXED_IRQ = 26;
  localparam logic [31:0] STS_IMPL_MASK = 32'hFC00_0000;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;

  // ==========================================================
  // time-base bit chosen by a period code: base + 4 * code
  localparam logic [4:0] WDOG_TB_BASE = 5'h10;
  localparam logic [4:0] FIXED_TB_BASE = 5'h08;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] num;
    logic [31:0] data;
  } tmr_spr_req_t;

endpackage

// File: design/tmr_event_regs.sv
`timescale 1ns/100ps
module tmr_event_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire tmr_pkg::tmr_spr_req_t sprReq,
  input wire logic privileged,
  input wire logic tbTick,
  input wire logic [31:0] tbLow,
  output logic [31:0] sprRdData_q,
  output logic sprAck_q,
  output logic sprErr_q,
  output logic wdtIrq_q,
  output logic intervalIrq_q,
  output logic fitIrq_q,
  output logic [1:0] wdtResetReq_q
);

  // ==========================================================
  // decoding helpers
  function automatic logic [4:0] tbBitIdx(input logic [1:0] code, input logic [4:0] base);
    tbBitIdx = base + {1'b0, code, 2'b00};
  endfunction

  function automatic logic risingAt(input logic [31:0] now, input logic [31:0] prev,
                                    input logic [4:0] idx);
    risingAt = now[idx] & ~prev[idx];
  endfunction

  // ==========================================================
  // state
  // registered state and next values
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic [31:0] sts_q;
  logic [31:0] sts_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] rld_q;
  logic [31:0] rld_d;
  logic [31:0] tbPrev_q;
  logic [31:0] tbPrev_d;
  logic [31:0] rdData_d;
  logic ack_d;
  logic err_d;
  logic wdtIrq_d;
  logic intervalIrq_d;
  logic fitIrq_d;
  logic [1:0] resetReq_d;
  logic [2:0] irqStatus;
  logic [2:0] irqEnable;
  logic [2:0] irqNext;

  // decoded strobes and events
  logic access;
  logic wrCtl;
  logic wrSts;
  logic wrCnt;
  logic mapped;
  logic intervalEvt;
  logic fitEvt;
  logic wdtEvt;
  logic [1:0] kindNow;

  // ==========================================================
  // register number match
  function automatic logic numIs(input logic [9:0] num, input logic [9:0] target);
    numIs = (num == target);
  endfunction

  // ==========================================================
  // access decode
  always_comb begin
    access = sprReq.valid & privileged;
    // unmapped numbers still get an answer, flagged as an error
    mapped = numIs(sprReq.num, tmr_pkg::SPR_STATUS) |
             numIs(sprReq.num, tmr_pkg::SPR_CONTROL) |
             numIs(sprReq.num, tmr_pkg::SPR_INTERVAL);
    wrSts = access & sprReq.write & numIs(sprReq.num, tmr_pkg::SPR_STATUS);
    wrCtl = access & sprReq.write & numIs(sprReq.num, tmr_pkg::SPR_CONTROL);
    wrCnt = access & sprReq.write & numIs(sprReq.num, tmr_pkg::SPR_INTERVAL);
  end

  // ==========================================================
  // timer events
  always_comb begin
    tbPrev_d = tbLow;
    // a period change gives no extra edge: the newly chosen bit is compared with its own previous value
    // watchdog timeout edge
    wdtEvt = risingAt(tbLow, tbPrev_q,
                      tbBitIdx(ctl_q[tmr_pkg::CTL_WDOG_PERIOD +: 2], tmr_pkg::WDOG_TB_BASE));
    fitEvt = risingAt(tbLow, tbPrev_q,
                      tbBitIdx(ctl_q[tmr_pkg::CTL_FIXED_PERIOD +: 2], tmr_pkg::FIXED_TB_BASE));
    intervalEvt = tbTick & ~wrCnt & (cnt_q == 32'h0000_0001);
  end

  // the whole previous word is kept so a period change needs no extra state
  always_ff @(posedge mclk) begin
    if (rst) begin
      tbPrev_q <= tmr_pkg::COUNT_RESET;
    end else begin
      tbPrev_q <= tbPrev_d;
    end
  end

  // ==========================================================
  // interval counter
  always_comb begin
    cnt_d = cnt_q;
    rld_d = rld_q;
    // a write in the same cycle as a tick wins: no decrement, no event
    if (wrCnt) begin
      cnt_d = sprReq.data;
      rld_d = sprReq.data;
    end else if (tbTick && cnt_q != 32'h0000_0000) begin
      if (cnt_q == 32'h0000_0001 && ctl_q[tmr_pkg::CTL_AUTO_RELOAD]) begin
        cnt_d = rld_q;
      end else begin
        cnt_d = cnt_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= tmr_pkg::COUNT_RESET;
      rld_q <= tmr_pkg::COUNT_RESET;
    end else begin
      cnt_q <= cnt_d;
      rld_q <= rld_d;
    end
  end

  // ==========================================================
  // control register
  always_comb begin
    ctl_d = ctl_q;
    kindNow = ctl_q[tmr_pkg::CTL_WDOG_RESET_KIND +: 2];
    if (wrCtl) begin
      ctl_d = sprReq.data & tmr_pkg::CTL_IMPL_MASK;
      ctl_d[tmr_pkg::CTL_WDOG_RESET_KIND +: 2] = kindNow |
        sprReq.data[tmr_pkg::CTL_WDOG_RESET_KIND +: 2];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_q <= tmr_pkg::CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ==========================================================
  // status register and watchdog
  always_comb begin
    sts_d = sts_q;
    resetReq_d = 2'h0;
    if (wrSts) begin
      sts_d = sts_q & ~(sprReq.data & tmr_pkg::STS_IMPL_MASK);
    end
    // sets come after the clear so a same-cycle event is never lost
    if (intervalEvt) begin
      sts_d[tmr_pkg::STS_INTERVAL_IRQ] = 1'b1;
    end
    if (fitEvt) begin
      sts_d[tmr_pkg::STS_FIXED_IRQ] = 1'b1;
    end
    if (wdtEvt) begin
      if (!sts_q[tmr_pkg::STS_ARM_NEXT]) begin
        sts_d[tmr_pkg::STS_ARM_NEXT] = 1'b1;
      end else if (!sts_q[tmr_pkg::STS_WDOG_IRQ]) begin
        sts_d[tmr_pkg::STS_WDOG_IRQ] = 1'b1;
      end else if (kindNow != 2'h0) begin
        resetReq_d = kindNow;
        sts_d[tmr_pkg::STS_WDOG_CAUSE +: 2] = kindNow;
      end
    end
  end

  // the reset request is a one-cycle pulse; the cause field keeps the kind
  always_ff @(posedge mclk) begin
    if (rst) begin
      sts_q <= tmr_pkg::STS_RESET;
      wdtResetReq_q <= 2'h0;
    end else begin
      sts_q <= sts_d;
      wdtResetReq_q <= resetReq_d;
    end
  end

  // ==========================================================
  // interrupt requests
  always_comb begin
    irqStatus[0] = sts_d[tmr_pkg::STS_WDOG_IRQ];
    irqEnable[0] = ctl_d[tmr_pkg::CTL_WDOG_IRQ_EN];
    irqStatus[1] = sts_d[tmr_pkg::STS_INTERVAL_IRQ];
    irqEnable[1] = ctl_d[tmr_pkg::CTL_INTERVAL_IRQ_EN];
    irqStatus[2] = sts_d[tmr_pkg::STS_FIXED_IRQ];
    irqEnable[2] = ctl_d[tmr_pkg::CTL_FIXED_IRQ_EN];
  end

  // one gate per request; the core applies its own global enable
  for (genvar i = 0; i < 3; i++) begin : g_irq
    assign irqNext[i] = irqStatus[i] & irqEnable[i];
  end

  always_comb begin
    wdtIrq_d = irqNext[0];
    intervalIrq_d = irqNext[1];
    fitIrq_d = irqNext[2];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdtIrq_q <= 1'b0;
      intervalIrq_q <= 1'b0;
      fitIrq_q <= 1'b0;
    end else begin
      wdtIrq_q <= wdtIrq_d;
      intervalIrq_q <= intervalIrq_d;
      fitIrq_q <= fitIrq_d;
    end
  end

  // ==========================================================
  // read answer
  always_comb begin
    ack_d = sprReq.valid;
    err_d = sprReq.valid & ~(privileged & mapped);
    rdData_d = 32'h0000_0000;
    // reads return the state before any same-cycle write
    if (access && !sprReq.write) begin
      unique case (sprReq.num)
        tmr_pkg::SPR_STATUS: rdData_d = sts_q;
        tmr_pkg::SPR_CONTROL: rdData_d = ctl_q;
        tmr_pkg::SPR_INTERVAL: rdData_d = cnt_q;
        default: rdData_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sprRdData_q <= 32'h0000_0000;
      sprAck_q <= 1'b0;
      sprErr_q <= 1'b0;
    end else begin
      sprRdData_q <= rdData_d;
      sprAck_q <= ack_d;
      sprErr_q <= err_d;
    end
  end

endmodule

// File: verification/tmr_event_regs_properties.sv
`timescale 1ns/100ps
module tmr_event_regs_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire tmr_pkg::tmr_spr_req_t sprReq,
  input wire logic privileged,
  input wire logic tbTick,
  input wire logic [31:0] tbLow,
  input wire logic [31:0] sprRdData_q,
  input wire logic sprAck_q,
  input wire logic sprErr_q,
  input wire logic wdtIrq_q,
  input wire logic intervalIrq_q,
  input wire logic fitIrq_q,
  input wire logic [1:0] wdtResetReq_q
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========
  // register moves
  a_ack_pulse: assert property (sprAck_q == $past(sprReq.valid)) else $error("ack");
  a_err_unpriv: assert property (sprReq.valid && !privileged |=> sprErr_q) else $error("priv");
  a_err_unmap: assert property (sprReq.valid && sprReq.num[9:3] != 7'h7B |=> sprErr_q) else $error("map");
  a_ok_map: assert property (sprReq.valid && privileged && sprReq.num == tmr_pkg::SPR_CONTROL
    |=> !sprErr_q) else $error("ok");
  a_idle_zero: assert property (!sprAck_q |-> sprRdData_q == 32'h0) else $error("idle");
  a_ctl_rsvd: assert property (sprAck_q && $past(sprReq.num) == tmr_pkg::SPR_CONTROL
    |-> sprRdData_q[21:0] == 22'h0) else $error("ctl");
  a_sts_rsvd: assert property (sprAck_q && $past(sprReq.num) == tmr_pkg::SPR_STATUS
    |-> sprRdData_q[25:0] == 26'h0) else $error("sts");
  // ==========
  // watchdog reset request is a single pulse
  a_reset_pulse: assert property (wdtResetReq_q != 2'h0 |=> wdtResetReq_q == 2'h0) else $error("rq");
  c_ctl_wr: cover property (sprReq.valid && sprReq.write && sprReq.num == tmr_pkg::SPR_CONTROL);
  c_rst_rq: cover property (wdtResetReq_q != 2'h0);
  c_interval_irq: cover property ($rose(intervalIrq_q));
endmodule
bind tmr_event_regs tmr_event_regs_properties chk_u (.mclk, .rst, .sprReq, .privileged, .tbTick, .tbLow,
  .sprRdData_q, .sprAck_q, .sprErr_q, .wdtIrq_q, .intervalIrq_q, .fitIrq_q, .wdtResetReq_q);

// File: verification/tmr_core_model.sv
`timescale 1ns/100ps
module tmr_core_model (
  input wire logic mclk,
  output tmr_pkg::tmr_spr_req_t sprReq,
  output logic privileged,
  input wire logic [31:0] sprRdData_q,
  input wire logic sprAck_q,
  input wire logic sprErr_q
);
  initial begin
    sprReq = '0;
    privileged = 1'b0;
  end
  task automatic spr(input logic w, input logic p, input logic [9:0] n, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    @(negedge mclk);
    sprReq = '{1'b1, w, n, d};
    privileged = p;
    @(negedge mclk);
    // released lines show the inverse, never a stale value
    sprReq = '{1'b0, ~w, ~n, ~d};
    privileged = ~p;
    rd = sprAck_q ? sprRdData_q : 32'hX;
    er = sprErr_q;
  endtask
endmodule

// File: verification/tb_timer_event_registers.sv
`timescale 1ns/100ps
module tb_timer_event_registers;
  logic mclk, rst, tbTick, privileged, sprAck_q, sprErr_q, wdtIrq_q, intervalIrq_q, fitIrq_q, er;
  logic [31:0] tbLow, sprRdData_q, rd, d;
  logic [1:0] wdtResetReq_q, seen;
  logic [9:0] nums [3];
  tmr_pkg::tmr_spr_req_t sprReq;
  int failures, tests_run, seed;
  tmr_event_regs dut_u (.mclk, .rst, .sprReq, .privileged, .tbTick, .tbLow, .sprRdData_q, .sprAck_q,
    .sprErr_q, .wdtIrq_q, .intervalIrq_q, .fitIrq_q, .wdtResetReq_q);
  tmr_core_model core_u (.mclk, .sprReq, .privileged, .sprRdData_q, .sprAck_q, .sprErr_q);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // the request pulse lasts one cycle, so it is latched here
  always @(posedge mclk) begin
    if (wdtResetReq_q !== 2'h0) begin
      seen <= wdtResetReq_q;
    end
  end
  function automatic logic [31:0] ctlExp(input logic [31:0] old, input logic [31:0] w);
    return (w & tmr_pkg::CTL_IMPL_MASK) | (old & 32'h3000_0000);
  endfunction
  task automatic results();
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] n, input logic [31:0] v);
    core_u.spr(1'b1, 1'b1, n, v, rd, er);
  endtask
  task automatic rd_chk(input logic [9:0] n, input logic [31:0] exp);
    core_u.spr(1'b0, 1'b1, n, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge mclk);
      tbTick = 1'b1;
      @(negedge mclk);
      tbTick = 1'b0;
    end
  endtask
  task automatic rise(input int b);
    @(negedge mclk);
    tbLow[b] = 1'b0;
    @(negedge mclk);
    tbLow[b] = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic reset_chk();
    for (int i = 0; i < 3; i++) begin
      rd_chk(nums[i], 32'h0);
    end
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    failures = 0;
    tests_run = 0;
    seed = 17779;
    seen = 2'h0;
    nums = '{tmr_pkg::SPR_STATUS, tmr_pkg::SPR_CONTROL, tmr_pkg::SPR_INTERVAL};
    tbTick = 1'b0;
    tbLow = 32'h0;
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    reset_chk();
    core_u.spr(1'b1, 1'b0, nums[1], 32'hFFFF_FFFF, rd, er);
    chk(er, 1);
    core_u.spr(1'b0, 1'b1, 10'h1DA, 32'h0, rd, er);
    chk(er, 1);
    rd_chk(nums[1], 32'h0);
    repeat (4) begin
      d = $random(seed) & 32'hCFFF_FFFF;
      wr(nums[1], d);
      rd_chk(nums[1], ctlExp(32'h0, d));
    end
    wr(nums[1], 32'h0);
    d = ($random(seed) & 32'hFF) + 5;
    wr(nums[2], d);
    tick(3);
    rd_chk(nums[2], d - 3);
    wr(nums[2], 32'h2);
    tick(3);
    rd_chk(nums[2], 32'h0);
    rd_chk(nums[0], 32'h0800_0000);
    wr(nums[1], 32'h0400_0000);
    @(negedge mclk);
    chk(intervalIrq_q, 1);
    wr(nums[0], 32'h0800_0000);
    @(negedge mclk);
    chk(intervalIrq_q, 0);
    rd_chk(nums[0], 32'h0);
    wr(nums[1], 32'h0040_0000);
    wr(nums[2], 32'h3);
    tick(3);
    rd_chk(nums[2], 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(nums[0], 32'hFFFF_FFFF);
      wr(nums[1], (32'(c) << 24) | 32'h0080_0000);
      rise(8 + 4 * c);
      // bit 16 also arms the watchdog on code 2
      rd_chk(nums[0], c == 2 ? 32'h8400_0000 : 32'h0400_0000);
      chk(fitIrq_q, 1);
    end
    wr(nums[0], 32'hFFFF_FFFF);
    wr(nums[1], 32'h1800_0000);
    rise(16);
    rd_chk(nums[0], 32'h8000_0000);
    rise(16);
    rd_chk(nums[0], 32'hC000_0000);
    chk(wdtIrq_q, 1);
    rise(16);
    rd_chk(nums[0], 32'hD000_0000);
    chk(seen, 1);
    wr(nums[1], 32'h0);
    rd_chk(nums[1], ctlExp(32'h1000_0000, 32'h0));
    rst = 1'b1;
    // time-base bits left high would give false edges right after release
    tbLow = 32'h0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    reset_chk();
    results();
  end
endmodule
